// ===== src/duc_ctrl.sv
// DAC output update, clear, busy, power-down and toggle controller
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "duc_defs.svh"

module duc_ctrl
  import duc_pkg::*;
#(
  parameter int NCH = 32,
  parameter int DW = 16,
  parameter int CW = 5
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire duc_req_s bus_req,
  output logic [15:0] bus_rdata,
  input wire logic output_clear_n,
  input wire logic load_outputs_n,
  input wire logic busy_n_i,
  output logic busy_n_o,
  output logic busy_n_oe,
  input wire logic die_over_temp,
  output logic [NCH-1:0][DW-1:0] dac_code,
  output logic signal_ground_ref
);

  localparam int NSEL = NCH / 8;

  duc_state_e state_reg;
  duc_ctrl_s ctrl_reg;
  logic therm_flag_reg;
  logic [7:0] cnt_reg;
  logic [7:0] sel_cnt_reg;
  logic [NCH-1:0] pend_a_reg;
  logic [NCH-1:0] pend_b_reg;
  logic [NCH-1:0] changed_reg;
  logic [NCH-1:0] level_select_bit;
  logic [DW-1:0] input_reg_first [NCH];
  logic [DW-1:0] input_reg_second [NCH];
  logic [DW-1:0] gain_reg [NCH];
  logic [DW-1:0] offs_reg [NCH];
  logic [DW-1:0] corrected_reg_first [NCH];
  logic [DW-1:0] corrected_reg_second [NCH];
  logic [NCH-1:0][DW-1:0] dac_reg;
  logic [15:0] rdata_reg;
  logic busy_oe_reg;
  logic ground_reg;
  logic cleared_reg;
  logic load_prev_reg;
  logic load_pend_reg;

  logic [NCH-1:0] wr_mask;
  logic wr_in;
  logic wr_gain;
  logic wr_offs;
  logic wr_ctrl;
  logic wr_sel;
  logic stage_end;
  logic final_end;
  logic pick_any;
  logic [CW-1:0] pick_idx;
  logic [NCH-1:0] done_mask;
  logic own_busy;
  logic busy_any;
  logic clr_active;
  logic do_load;
  logic load_fall;
  logic therm_sd;
  logic [NCH-1:0] sel_touch;

  // Channel mask from an address; bit 5 addresses every channel
  function automatic logic [NCH-1:0] ch_mask(input logic [7:0] a);
    logic [NCH-1:0] m;
    m = '0;
    if (a[`DUC_B_ALL]) begin
      m = '1;
    end else begin
      m[a[CW-1:0]] = 1'b1;
    end
    return m;
  endfunction

  // Corrected code: x*(m+1)/2^DW + c - 2^(DW-1), clamped to range
  function automatic logic [DW-1:0] corr_calc(input logic [DW-1:0] x,
                                              input logic [DW-1:0] m,
                                              input logic [DW-1:0] c);
    logic [2*DW:0] prod;
    logic signed [DW+2:0] t;
    prod = (2*DW+1)'(x) * ((2*DW+1)'(m) + (2*DW+1)'(1));
    t = $signed({2'b00, prod[2*DW:DW]}) + $signed({3'b000, c})
        - $signed((DW+3)'(1) <<< (DW-1));
    if (t < 0) begin
      return '0;
    end else if (t[DW+2:DW] != 3'b000) begin
      return '1;
    end
    return t[DW-1:0];
  endfunction

  always_comb begin
    wr_mask = ch_mask(bus_req.addr);
    wr_in = bus_req.wr && (bus_req.addr[7:6] == `DUC_K_IN);
    wr_gain = bus_req.wr && (bus_req.addr[7:6] == `DUC_K_GAIN);
    wr_offs = bus_req.wr && (bus_req.addr[7:6] == `DUC_K_OFFS);
    wr_ctrl = bus_req.wr && (bus_req.addr == `DUC_A_CTRL);
    wr_sel = bus_req.wr && (bus_req.addr[7:2] == `DUC_A_SEL_HI);
  end

  // Lowest pending channel goes through the multiplier next
  always_comb begin
    pick_any = 1'b0;
    pick_idx = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (pend_a_reg[i] || pend_b_reg[i]) begin
        pick_any = 1'b1;
        pick_idx = CW'(i);
      end
    end
  end

  always_comb begin
    stage_end = (state_reg == DUC_STAGE) &&
                (cnt_reg == 8'(`DUC_STAGE_CYC - 1));
    final_end = (state_reg == DUC_FINAL) &&
                (cnt_reg == 8'(`DUC_FINAL_CYC - 1));
    done_mask = '0;
    if (stage_end && pick_any) begin
      done_mask[pick_idx] = 1'b1;
    end
  end

  always_comb begin
    own_busy = (state_reg != DUC_IDLE) || (|pend_a_reg) ||
               (|pend_b_reg) || (sel_cnt_reg != 8'h00);
    busy_any = own_busy || !busy_n_i;
    clr_active = !output_clear_n;
    load_fall = load_prev_reg && !load_outputs_n;
    do_load = !clr_active && !busy_any &&
              (load_pend_reg || !load_outputs_n);
    therm_sd = ctrl_reg.therm_en && therm_flag_reg;
    sel_touch = '0;
    if (wr_sel) begin
      sel_touch[bus_req.addr[1:0]*8 +: 8] = 8'hFF;
    end
  end

  // Input, gain and offset registers, written even while busy
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (!rstn) begin
        input_reg_first[i] <= `DUC_RST_IN;
        input_reg_second[i] <= `DUC_RST_IN;
        gain_reg[i] <= `DUC_RST_GAIN;
        offs_reg[i] <= `DUC_RST_OFFS;
      end else if (wr_mask[i]) begin
        if (wr_in && !ctrl_reg.ab_sel) begin
          input_reg_first[i] <= bus_req.wdata[DW-1:0];
        end
        if (wr_in && ctrl_reg.ab_sel) begin
          input_reg_second[i] <= bus_req.wdata[DW-1:0];
        end
        if (wr_gain) begin
          gain_reg[i] <= bus_req.wdata[DW-1:0];
        end
        if (wr_offs) begin
          offs_reg[i] <= bus_req.wdata[DW-1:0];
        end
      end
    end
  end

  // Pending recompute; a new write wins over completion
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pend_a_reg <= '0;
      pend_b_reg <= '0;
    end else begin
      pend_a_reg <= (pend_a_reg & ~done_mask) |
                    (wr_mask & {NCH{wr_gain || wr_offs ||
                                    (wr_in && !ctrl_reg.ab_sel)}});
      pend_b_reg <= (pend_b_reg & ~done_mask) |
                    (wr_mask & {NCH{wr_gain || wr_offs ||
                                    (wr_in && ctrl_reg.ab_sel)}});
    end
  end

  // Stage sequencer: one stage per channel, one more, then final
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_reg <= DUC_IDLE;
      cnt_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        DUC_IDLE: begin
          cnt_reg <= 8'h00;
          if (pick_any) begin
            state_reg <= DUC_STAGE;
          end
        end
        DUC_STAGE: begin
          if (stage_end) begin
            cnt_reg <= 8'h00;
            if (!pick_any) begin
              state_reg <= DUC_FINAL;
            end
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        DUC_FINAL: begin
          if (final_end) begin
            cnt_reg <= 8'h00;
            state_reg <= pick_any ? DUC_STAGE : DUC_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
      endcase
    end
  end

  // Shared multiplier commits one channel per stage
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (!rstn) begin
        corrected_reg_first[i] <= `DUC_RST_CORR;
        corrected_reg_second[i] <= `DUC_RST_CORR;
      end else if (done_mask[i]) begin
        if (pend_a_reg[i]) begin
          corrected_reg_first[i] <= corr_calc(input_reg_first[i],
                                              gain_reg[i],
                                              offs_reg[i]);
        end
        if (pend_b_reg[i]) begin
          corrected_reg_second[i] <= corr_calc(input_reg_second[i],
                                               gain_reg[i],
                                               offs_reg[i]);
        end
      end
    end
  end

  // Level-select registers and their busy window
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      level_select_bit <= '0;
      sel_cnt_reg <= 8'h00;
    end else begin
      if (wr_sel) begin
        level_select_bit[bus_req.addr[1:0]*8 +: 8] <=
          bus_req.wdata[7:0];
        sel_cnt_reg <= 8'(`DUC_SEL_CYC);
      end else if (sel_cnt_reg != 8'h00) begin
        sel_cnt_reg <= sel_cnt_reg - 8'h01;
      end
    end
  end

  // Load event capture; clear discards it
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      load_prev_reg <= 1'b1;
      load_pend_reg <= 1'b0;
    end else begin
      load_prev_reg <= load_outputs_n;
      if (clr_active) begin
        load_pend_reg <= 1'b0;
      end else begin
        load_pend_reg <= load_fall || (load_pend_reg && !do_load);
      end
    end
  end

  // Change tracking; fresh change wins over a load
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      changed_reg <= '0;
    end else begin
      changed_reg <= (changed_reg & ~{NCH{do_load}}) | done_mask |
                     sel_touch;
    end
  end

  // Per-channel DAC registers; clear leaves them alone
  for (genvar g = 0; g < NCH; g++) begin : g_dac
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        dac_reg[g] <= `DUC_RST_CORR;
      end else if (do_load && changed_reg[g]) begin
        dac_reg[g] <= level_select_bit[g] ? corrected_reg_second[g]
                                          : corrected_reg_first[g];
      end
    end
  end

  // Control and thermal flag
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_reg <= '0;
      therm_flag_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg.pwr_down <= bus_req.wdata[`DUC_B_PD];
        ctrl_reg.therm_en <= bus_req.wdata[`DUC_B_TEN];
        ctrl_reg.ab_sel <= bus_req.wdata[`DUC_B_AB];
      end
      if (!ctrl_reg.therm_en) begin
        therm_flag_reg <= 1'b0;
      end else if (die_over_temp) begin
        therm_flag_reg <= 1'b1;
      end
    end
  end

  // Cleared output state and ground switch
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cleared_reg <= 1'b0;
      ground_reg <= 1'b1;
    end else begin
      if (clr_active) begin
        cleared_reg <= 1'b1;
      end else if (do_load) begin
        cleared_reg <= 1'b0;
      end
      ground_reg <= clr_active || cleared_reg || ctrl_reg.pwr_down ||
                    therm_sd;
    end
  end

  // Open-drain busy driver
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      busy_oe_reg <= 1'b0;
    end else begin
      busy_oe_reg <= own_busy;
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= 16'h0000;
      if (bus_req.rd) begin
        if (bus_req.addr == `DUC_A_CTRL) begin
          rdata_reg[`DUC_B_PD] <= ctrl_reg.pwr_down;
          rdata_reg[`DUC_B_TEN] <= ctrl_reg.therm_en;
          rdata_reg[`DUC_B_AB] <= ctrl_reg.ab_sel;
          rdata_reg[`DUC_B_TFLAG] <= therm_flag_reg;
        end else if (bus_req.addr == `DUC_A_STAT) begin
          rdata_reg[3:0] <= {cleared_reg, load_pend_reg, !busy_n_i,
                             own_busy};
        end else if (bus_req.addr[7:2] == `DUC_A_SEL_HI) begin
          rdata_reg[7:0] <= level_select_bit[bus_req.addr[1:0]*8 +: 8];
        end else if (bus_req.addr[7:5] == `DUC_A_DAC_HI) begin
          rdata_reg[DW-1:0] <= dac_reg[bus_req.addr[CW-1:0]];
        end else if (bus_req.addr[7:6] == `DUC_K_IN) begin
          rdata_reg[DW-1:0] <= ctrl_reg.ab_sel ?
                               input_reg_second[bus_req.addr[CW-1:0]] :
                               input_reg_first[bus_req.addr[CW-1:0]];
        end else if (bus_req.addr[7:6] == `DUC_K_GAIN) begin
          rdata_reg[DW-1:0] <= gain_reg[bus_req.addr[CW-1:0]];
        end else if (bus_req.addr[7:6] == `DUC_K_OFFS) begin
          rdata_reg[DW-1:0] <= offs_reg[bus_req.addr[CW-1:0]];
        end
      end
    end
  end

  assign bus_rdata = rdata_reg;
  assign busy_n_o = 1'b0;
  assign busy_n_oe = busy_oe_reg;
  assign dac_code = dac_reg;
  assign signal_ground_ref = ground_reg;

endmodule // duc_ctrl

// ===== src/duc_defs.svh
// Constants for the DAC update, clear and toggle controller
`ifndef DUC_DEFS_SVH
`define DUC_DEFS_SVH

`define DUC_CLK_NS 4
`define DUC_STAGE_NS 500
`define DUC_FINAL_NS 250
`define DUC_SEL_NS 500
`define DUC_STAGE_CYC (`DUC_STAGE_NS / `DUC_CLK_NS)
`define DUC_FINAL_CYC (`DUC_FINAL_NS / `DUC_CLK_NS)
`define DUC_SEL_CYC (`DUC_SEL_NS / `DUC_CLK_NS)

`define DUC_A_CTRL 8'h00
`define DUC_A_STAT 8'h01
`define DUC_A_SEL_HI 6'h01
`define DUC_A_DAC_HI 3'h1
`define DUC_K_IN 2'h1
`define DUC_K_GAIN 2'h2
`define DUC_K_OFFS 2'h3

`define DUC_B_PD 0
`define DUC_B_TEN 1
`define DUC_B_AB 2
`define DUC_B_TFLAG 4
`define DUC_B_ALL 5

`define DUC_RST_IN 16'h5554
`define DUC_RST_GAIN 16'hFFFF
`define DUC_RST_OFFS 16'h8000
`define DUC_RST_CORR 16'h5554

`endif

// ===== src/duc_pkg.sv
// Types shared by the DAC update controller
package duc_pkg;

  typedef enum logic [2:0] {
    DUC_IDLE  = 3'b001,
    DUC_STAGE = 3'b010,
    DUC_FINAL = 3'b100
  } duc_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } duc_req_s;

  typedef struct packed {
    logic ab_sel;
    logic therm_en;
    logic pwr_down;
  } duc_ctrl_s;

endpackage

// ===== tb/duc_ctrl_properties.sv
// Pin-level checks for the DAC update controller
`timescale 1ns/1ps
module duc_ctrl_properties
  import duc_pkg::*;
#(
  parameter int NCH = 32,
  parameter int DW = 16
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire duc_req_s bus_req,
  input wire logic output_clear_n,
  input wire logic load_outputs_n,
  input wire logic busy_n_i,
  input wire logic busy_n_o,
  input wire logic busy_n_oe,
  input wire logic [NCH-1:0][DW-1:0] dac_code,
  input wire logic signal_ground_ref
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [15:0] run_reg;
  always_ff @(posedge sys_clk) begin
    if (!rstn) run_reg <= 16'h0000;
    else run_reg <= busy_n_oe ? run_reg + 16'h0001 : 16'h0000;
  end
  sequence s_calc_wr;
    bus_req.wr && bus_req.addr[7:6] != 2'h0;
  endsequence
  sequence s_sel_wr;
    bus_req.wr && bus_req.addr[7:2] == 6'h01;
  endsequence
  property p_clr_gnd;
    !output_clear_n |=> signal_ground_ref;
  endproperty
  a_clr_gnd: assert property (p_clr_gnd) else $error("clear not grounding");
  property p_clr_hold;
    !output_clear_n |=> $stable(dac_code);
  endproperty
  a_clr_hold: assert property (p_clr_hold) else $error("load during clear");
  property p_clr_rel;
    $rose(output_clear_n) && load_outputs_n |=> signal_ground_ref;
  endproperty
  a_clr_rel: assert property (p_clr_rel) else $error("clear ended early");
  property p_calc_busy;
    s_calc_wr |-> ##2 busy_n_oe;
  endproperty
  a_calc_busy: assert property (p_calc_busy) else $error("no busy on write");
  property p_busy_hold;
    !busy_n_i |=> $stable(dac_code);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("update while busy");
  property p_open_drain;
    busy_n_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("busy drives high");
  property p_load_gate;
    $changed(dac_code) |-> $past(busy_n_i) && $past(output_clear_n);
  endproperty
  a_load_gate: assert property (p_load_gate) else $error("ungated update");
  property p_sel_busy;
    s_sel_wr |-> ##[1:3] busy_n_oe;
  endproperty
  a_sel_busy: assert property (p_sel_busy) else $error("no select busy");
  property p_busy_len;
    $fell(busy_n_oe) |-> run_reg >= 16'h0078 && run_reg <= 16'h1068;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length");
endmodule // duc_ctrl_properties

// ===== tb/duc_host_model.sv
// Host pin driver and a second device on the shared busy wire
`timescale 1ns/1ps
module duc_host_model (
  input wire logic sys_clk,
  output logic load_outputs_n,
  output logic output_clear_n,
  output logic other_busy_oe
);
  initial begin
    load_outputs_n = 1'b1;
    output_clear_n = 1'b1;
    other_busy_oe = 1'b0;
  end
  task automatic pulse();
    @(posedge sys_clk);
    load_outputs_n <= 1'b0;
    @(posedge sys_clk);
    load_outputs_n <= 1'b1;
  endtask
  task automatic drive(input logic ld_n, input logic clr_n);
    @(posedge sys_clk);
    load_outputs_n <= ld_n;
    output_clear_n <= clr_n;
  endtask
  task automatic hold_busy(input int n);
    @(posedge sys_clk);
    other_busy_oe <= 1'b1;
    repeat (n) @(posedge sys_clk);
    other_busy_oe <= 1'b0;
  endtask
endmodule // duc_host_model

// ===== tb/duc_ctrl_tb.sv
// Self-checking bench for the DAC update controller
`timescale 1ns/1ps
`include "duc_defs.svh"
module duc_ctrl_tb;
  import duc_pkg::*;
  localparam int NCH = 32;
  localparam int DW = 16;
  localparam int STG = `DUC_STAGE_CYC;
  localparam int FIN = `DUC_FINAL_CYC;
  typedef logic [NCH-1:0][DW-1:0] duc_vec_t;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  duc_req_s bus_req = '0;
  logic die_over_temp = 1'b0;
  logic rd_q = 1'b0;
  logic [15:0] bus_rdata, v, w;
  logic load_outputs_n, output_clear_n, other_busy_oe, busy_n_o, busy_n_oe;
  logic signal_ground_ref;
  duc_vec_t dac_code;
  duc_vec_t cur = {NCH{16'h5554}};
  duc_vec_t last = {NCH{16'h5554}};
  duc_vec_t dq[$];
  logic [15:0] rq[$];
  logic [31:0] lf = 32'hA72F;
  int err_count = 0;
  int n_compared = 0;
  wire busy_n_i = !(busy_n_oe || other_busy_oe);
  always #2 sys_clk = ~sys_clk;
  duc_ctrl #(.NCH(NCH), .DW(DW), .CW(5)) dut (.sys_clk(sys_clk),
    .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .output_clear_n(output_clear_n), .load_outputs_n(load_outputs_n),
    .busy_n_i(busy_n_i), .busy_n_o(busy_n_o), .busy_n_oe(busy_n_oe),
    .die_over_temp(die_over_temp), .dac_code(dac_code),
    .signal_ground_ref(signal_ground_ref));
  duc_host_model m (.sys_clk(sys_clk), .load_outputs_n(load_outputs_n),
    .output_clear_n(output_clear_n), .other_busy_oe(other_busy_oe));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic stop_test();
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus_req <= {1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    rq.push_back(e);
    @(posedge sys_clk);
    bus_req <= {1'b0, 1'b1, a, 16'h0000};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask
  task automatic busy_len(input int e);
    int n;
    n = 0;
    while (busy_n_oe !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    n = 0;
    while (busy_n_oe === 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
    chk(n >= e - 5 && n <= e + 2, "busy width");
  endtask
  always @(posedge sys_clk) rd_q <= bus_req.rd;
  always @(negedge sys_clk) begin
    if (rd_q === 1'b1) begin
      if (rq.size() == 0) chk(1'b0, "extra read");
      else chk(bus_rdata === rq.pop_front(), "read data");
    end
    if (rstn && dac_code !== last) begin
      if (dq.size() == 0) chk(1'b0, "unexpected update");
      else chk(dac_code === dq.pop_front(), "dac code");
      last = dac_code;
    end
  end
  initial begin
    tick(40000);
    err_count++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(8'h00, 16'h0000);
    rd(8'h02, 16'h0000);
    lf = lfsr(lf);
    v = lf[15:0] | 16'h0001;
    w = v ^ 16'h0F00;
    cur[3] = v;
    dq.push_back(cur);
    wr(8'h43, v);
    m.pulse();
    busy_len(2 * STG + FIN);
    tick(4);
    wr(8'h00, 16'h0004);
    wr(8'h60, w);
    busy_len(33 * STG + FIN);
    rd(8'h43, w);
    wr(8'h04, 16'h000F);
    busy_len(STG);
    for (int i = 0; i < 4; i++) cur[i] = w;
    dq.push_back(cur);
    m.pulse();
    tick(4);
    m.drive(1'b1, 1'b0);
    wr(8'hC9, 16'h8010);
    wr(8'h89, 16'h7FFF);
    busy_len(2 * STG + FIN);
    m.pulse();
    tick(3);
    chk(signal_ground_ref === 1'b1, "clear grounds");
    rd(8'h23, w);
    rd(8'h01, 16'h0008);
    m.drive(1'b1, 1'b1);
    tick(6);
    chk(signal_ground_ref === 1'b1, "stays cleared");
    // 0x5554 * 2^15 / 2^16 + 0x8010 - 0x8000
    cur[9] = 16'h2ABA;
    dq.push_back(cur);
    m.pulse();
    tick(4);
    chk(signal_ground_ref === 1'b0, "load ends clear");
    m.drive(1'b0, 1'b1);
    for (int i = 0; i < 3; i++) cur[i] = 16'h5554;
    cur[3] = v;
    dq.push_back(cur);
    fork
      m.hold_busy(400);
      begin
        wr(8'h04, 16'h0000);
        tick(200);
        chk(dac_code[3] === w, "held by other busy");
      end
    join
    tick(4);
    chk(dac_code[3] === v, "held load updates");
    m.drive(1'b1, 1'b1);
    wr(8'h00, 16'h0001);
    tick(2);
    chk(signal_ground_ref === 1'b1, "power down");
    rd(8'h23, v);
    wr(8'h00, 16'h0000);
    tick(2);
    chk(signal_ground_ref === 1'b0, "power up");
    wr(8'h00, 16'h0002);
    tick(3);
    chk(signal_ground_ref === 1'b0, "cool die");
    @(posedge sys_clk);
    die_over_temp <= 1'b1;
    tick(3);
    @(posedge sys_clk);
    die_over_temp <= 1'b0;
    tick(20);
    chk(signal_ground_ref === 1'b1, "thermal off");
    rd(8'h00, 16'h0012);
    wr(8'h00, 16'h0000);
    tick(2);
    chk(signal_ground_ref === 1'b0, "thermal end");
    rd(8'h00, 16'h0000);
    tick(4);
    chk(dq.size() == 0 && rq.size() == 0, "notes left");
    stop_test();
  end
endmodule // duc_ctrl_tb
bind duc_ctrl duc_ctrl_properties #(.NCH(NCH), .DW(DW)) u_props (
  .sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req),
  .output_clear_n(output_clear_n), .load_outputs_n(load_outputs_n),
  .busy_n_i(busy_n_i), .busy_n_o(busy_n_o), .busy_n_oe(busy_n_oe),
  .dac_code(dac_code), .signal_ground_ref(signal_ground_ref));
